// >>> hw/ppw_pkg.sv
// Package with constants and types for the period and pulse width setup block.
package ppw_pkg;

  // Clock rate and derived timing.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned GATE_DEF_MS   = 400;
  localparam int unsigned GATE_DEF_CYC  = GATE_DEF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned PRELIM_US     = 10;
  localparam int unsigned PRELIM_CYC    = PRELIM_US * 1000 / CLK_PERIOD_NS;

  // Expected and resolution values are carried in picoseconds.
  localparam int unsigned VAL_W         = 64;
  localparam logic [63:0] PS_5NS        = 64'h0000_0000_0000_1388;
  localparam logic [63:0] PS_10NS       = 64'h0000_0000_0000_2710;
  localparam logic [63:0] PS_1NS        = 64'h0000_0000_0000_03E8;
  localparam logic [63:0] PS_15000S     = 64'h0035_4A6B_A7A1_8000;
  localparam logic [63:0] PS_4NS        = 64'h0000_0000_0000_0FA0;
  localparam logic [63:0] PS_100NS      = 64'h0000_0000_0001_86A0;
  localparam logic [63:0] PS_10MS       = 64'h0000_0002_540B_E400;

  // Pulse width averaging gate count, pulse width trigger default and limits, digits default and prescale divide.
  localparam logic [6:0]  AVG_GATES     = 7'h64;
  localparam logic [6:0]  REF_PCT_DEF   = 7'h32;
  localparam logic [6:0]  REF_PCT_MIN   = 7'h0A;
  localparam logic [6:0]  REF_PCT_MAX   = 7'h5A;
  localparam logic [3:0]  DIGITS_DEF    = 4'h9;
  localparam logic [1:0]  PRESCALE_DIV  = 2'h2;

  // Input and function selections.
  typedef enum logic [1:0] {PPW_IN1, PPW_IN2, PPW_IN3, PPW_IN_NONE} ppw_input_t;
  typedef enum logic [0:0] {PPW_FN_PERIOD, PPW_FN_POS_WIDTH} ppw_func_t;

  // One configuration command.
  typedef struct packed {
    ppw_func_t   func;
    logic        input_given;
    ppw_input_t  input_sel;
    logic        exp_given;
    logic [63:0] exp_ps;
    logic        res_given;
    logic [63:0] res_ps;
    logic        ref_given;
    logic        ref_percent_units;
    logic [6:0]  ref_pct;
  } ppw_cfg_t;

  // Derived measurement setup.
  typedef struct packed {
    ppw_func_t   func;
    ppw_input_t  input_sel;
    logic [63:0] gate_cyc;
    logic        prescale_on;
    logic        avg_on;
    logic        auto_trig;
    logic [6:0]  trig_pct;
    logic [3:0]  digits;
  } ppw_setup_t;

endpackage : ppw_pkg

// >>> hw/ppw_sync2.sv
// Two-flop synchroniser for one input pin.
`timescale 1ns/10ps
module ppw_sync2 (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_r;

  // The first stage is read only by the second stage.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      meta_r <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : ppw_sync2

// >>> hw/ppw_setup.sv
// Period and pulse width measurement setup and timing logic.
`timescale 1ns/10ps
module ppw_setup (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset,
  input  wire logic             i_cfg_valid,
  input  wire ppw_pkg::ppw_cfg_t i_cfg,
  input  wire logic             i_initiate,
  input  wire logic [2:0]       i_sig_in,
  output logic                  o_cfg_error,
  output ppw_pkg::ppw_setup_t   o_setup,
  output logic                  o_busy,
  output logic                  o_done,
  output logic [63:0]           o_time_count,
  output logic [63:0]           o_cycle_count,
  output logic [63:0]           o_period_ps
);

  typedef enum logic [2:0] {PPW_IDLE, PPW_ARM, PPW_GATE, PPW_W_RISE, PPW_W_FALL, PPW_PRELIM} ppw_state_t;

  ppw_state_t          state_r, state_nxt;
  ppw_pkg::ppw_setup_t setup_r;
  logic [2:0]          sig_s;
  logic [2:0]          sig_d_r;
  logic [63:0]         tcnt_r;
  logic [63:0]         ccnt_r;
  logic [63:0]         gate_left_r;
  logic [6:0]          gates_left_r;
  logic                prelim_pending_r;
  logic                prescale_ph_r;

  // Each measured input is synchronised before use.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      ppw_sync2 u_sync (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_async   (i_sig_in[g]),
        .o_sync    (sig_s[g])
      );
    end
  endgenerate

  // Input selection and validity checks on the incoming command.
  // default input
  ppw_pkg::ppw_input_t in_eff;
  assign in_eff = i_cfg.input_given ? i_cfg.input_sel : ppw_pkg::PPW_IN1;
  logic is_period;
  assign is_period = (i_cfg.func == ppw_pkg::PPW_FN_PERIOD);
  logic [63:0] exp_min;
  assign exp_min = (in_eff == ppw_pkg::PPW_IN1) ? ppw_pkg::PS_5NS : ppw_pkg::PS_10NS;
  logic per_range_ok;
  assign per_range_ok = !i_cfg.exp_given || (in_eff == ppw_pkg::PPW_IN3) ||
                        ((i_cfg.exp_ps >= exp_min) && (i_cfg.exp_ps <= ppw_pkg::PS_15000S));
  logic list_ok;
  assign list_ok = !i_cfg.res_given ||
                   (i_cfg.exp_given && (is_period || i_cfg.ref_given));
  logic input_ok;
  assign input_ok = (in_eff != ppw_pkg::PPW_IN_NONE) && (is_period || in_eff != ppw_pkg::PPW_IN3);
  logic ref_ok;
  assign ref_ok = is_period || !i_cfg.ref_given || !i_cfg.ref_percent_units ||
                  ((i_cfg.ref_pct >= ppw_pkg::REF_PCT_MIN) && (i_cfg.ref_pct <= ppw_pkg::REF_PCT_MAX));
  logic cfg_ok;
  assign cfg_ok = per_range_ok && list_ok && input_ok && ref_ok;

  // Period gate time: gate = (4 ns / res) * period, else the default gate.
  // gate from values
  logic [63:0] gate_ps_num;
  assign gate_ps_num = (i_cfg.res_ps == 64'h0) ? 64'h0 : (ppw_pkg::PS_4NS * i_cfg.exp_ps) / i_cfg.res_ps;
  logic [63:0] gate_cyc_num;
  assign gate_cyc_num = gate_ps_num / (64'(ppw_pkg::CLK_PERIOD_NS) * ppw_pkg::PS_1NS);
  logic [63:0] per_gate;
  assign per_gate = (i_cfg.exp_given && i_cfg.res_given && gate_cyc_num != 64'h0) ?
                    gate_cyc_num : 64'(ppw_pkg::GATE_DEF_CYC);
  logic per_prescale;
  assign per_prescale = (in_eff == ppw_pkg::PPW_IN1) &&
                        (!i_cfg.exp_given || (i_cfg.exp_ps < ppw_pkg::PS_10NS));
  logic width_avg;
  assign width_avg = i_cfg.res_given && (i_cfg.res_ps < ppw_pkg::PS_1NS);
  logic width_auto;
  assign width_auto = !i_cfg.ref_given || i_cfg.ref_percent_units;

  ppw_pkg::ppw_setup_t setup_nxt;
  always_comb begin
    setup_nxt           = setup_r;
    setup_nxt.func      = i_cfg.func;
    setup_nxt.input_sel = in_eff;
    if (is_period) begin
      setup_nxt.gate_cyc    = per_gate;
      setup_nxt.prescale_on = per_prescale;
      setup_nxt.avg_on      = 1'b0;
      setup_nxt.auto_trig   = 1'b1;
      setup_nxt.trig_pct    = ppw_pkg::REF_PCT_DEF;
      setup_nxt.digits      = ppw_pkg::DIGITS_DEF;
    end else begin
      setup_nxt.gate_cyc    = 64'h1;
      setup_nxt.prescale_on = 1'b0;
      setup_nxt.avg_on      = width_avg;
      setup_nxt.auto_trig   = width_auto;
      setup_nxt.trig_pct    = (i_cfg.ref_given && i_cfg.ref_percent_units) ? i_cfg.ref_pct : ppw_pkg::REF_PCT_DEF;
      setup_nxt.digits      = ppw_pkg::DIGITS_DEF;
    end
  end

  // Edge detection on the selected, synchronised input.
  logic sel_sig;
  assign sel_sig = sig_s[setup_r.input_sel[1:0] == 2'h3 ? 2'h0 : setup_r.input_sel[1:0]];
  logic sel_prev;
  assign sel_prev = sig_d_r[setup_r.input_sel[1:0] == 2'h3 ? 2'h0 : setup_r.input_sel[1:0]];
  logic rise;
  assign rise = sel_sig && !sel_prev;
  logic fall;
  assign fall = !sel_sig && sel_prev;
  // Divide-by-2 prescaler passes every second rising edge.
  logic cyc_edge;
  assign cyc_edge = rise && (!setup_r.prescale_on || prescale_ph_r);

  // Measurement sequencer.
  // wait for initiate
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PPW_IDLE:   if (i_initiate) state_nxt = prelim_pending_r ? PPW_PRELIM : PPW_ARM;
      PPW_PRELIM: if (gate_left_r == 64'h0) state_nxt = PPW_ARM;
      PPW_ARM:    if (rise) state_nxt = (setup_r.func == ppw_pkg::PPW_FN_PERIOD) ? PPW_GATE : PPW_W_FALL;
      PPW_GATE:   if (gate_left_r == 64'h0 && cyc_edge) state_nxt = PPW_IDLE;
      PPW_W_RISE: if (rise) state_nxt = PPW_W_FALL;
      PPW_W_FALL: if (fall) state_nxt = (gates_left_r > 7'h1) ? PPW_W_RISE : PPW_IDLE;
      default:    state_nxt = PPW_IDLE;
    endcase
  end

  // Counters and configuration storage.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_r          <= PPW_IDLE;
      setup_r          <= '0;
      sig_d_r          <= 3'h0;
      tcnt_r           <= 64'h0;
      ccnt_r           <= 64'h0;
      gate_left_r      <= 64'h0;
      gates_left_r     <= 7'h0;
      prelim_pending_r <= 1'b0;
      prescale_ph_r    <= 1'b0;
      o_cfg_error      <= 1'b0;
      o_done           <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sig_d_r <= sig_s;
      o_done  <= 1'b0;
      if (rise && state_r == PPW_GATE) prescale_ph_r <= !prescale_ph_r; // Only rising edges inside the gate toggle the divide; the arming edge does not.
      if (i_cfg_valid && state_r == PPW_IDLE) begin
        o_cfg_error <= !cfg_ok;
        if (cfg_ok) begin
          setup_r <= setup_nxt;
          prelim_pending_r <= !is_period && !i_cfg.exp_given && !i_cfg.res_given;
        end
      end
      if (state_r == PPW_IDLE && i_initiate) begin
        tcnt_r        <= 64'h0;
        ccnt_r        <= 64'h0;
        prescale_ph_r <= 1'b0;
        gate_left_r   <= prelim_pending_r ? 64'(ppw_pkg::PRELIM_CYC) : setup_r.gate_cyc;
        gates_left_r  <= setup_r.avg_on ? ppw_pkg::AVG_GATES : 7'h1;
      end
      if (state_r == PPW_PRELIM) begin
        gate_left_r <= (gate_left_r == 64'h0) ? setup_r.gate_cyc : gate_left_r - 64'h1;
        if (gate_left_r == 64'h0) prelim_pending_r <= 1'b0;
      end
      if (state_r == PPW_GATE) begin
        tcnt_r <= tcnt_r + 64'h1;
        if (gate_left_r != 64'h0) gate_left_r <= gate_left_r - 64'h1;
        if (cyc_edge) ccnt_r <= ccnt_r + 64'h1;
        if (state_nxt == PPW_IDLE) o_done <= 1'b1;
      end
      if (state_r == PPW_W_FALL) begin
        tcnt_r <= tcnt_r + 64'h1;
        if (fall) begin
          ccnt_r       <= ccnt_r + 64'h1;
          gates_left_r <= gates_left_r - 7'h1;
          if (state_nxt == PPW_IDLE) o_done <= 1'b1;
        end
      end
    end
  end

  // Result: time per counted cycle, scaled by the prescale factor.
  // period computation
  logic [63:0] per_ps;
  assign per_ps = (ccnt_r == 64'h0) ? 64'h0 :
                  (tcnt_r * 64'(ppw_pkg::CLK_PERIOD_NS) * ppw_pkg::PS_1NS) /
                  (setup_r.prescale_on ? ccnt_r * 64'(ppw_pkg::PRESCALE_DIV) : ccnt_r);

  // The result register follows the counts only while idle, so it stands during a run.
  logic [63:0] period_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      period_r <= 64'h0;
    end else if (state_r == PPW_IDLE) begin
      period_r <= per_ps;
    end
  end

  assign o_setup       = setup_r;
  assign o_busy        = (state_r != PPW_IDLE);
  assign o_time_count  = tcnt_r;
  assign o_cycle_count = ccnt_r;
  assign o_period_ps   = period_r;

  a_no_auto_start: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_r == PPW_IDLE && !i_initiate) |=> state_r == PPW_IDLE)
    else $error("acquisition started without initiate");
  a_width_in3_refused: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_cfg_valid && state_r == PPW_IDLE && i_cfg.func == ppw_pkg::PPW_FN_POS_WIDTH &&
     i_cfg.input_given && i_cfg.input_sel == ppw_pkg::PPW_IN3) |=> o_cfg_error && $stable(setup_r))
    else $error("pulse width accepted on input 3");
  a_width_ends_fall: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_r == PPW_W_FALL && !fall) |=> !o_done)
    else $error("width done without falling edge");
  a_prescale_low_exp: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_cfg_valid && state_r == PPW_IDLE && cfg_ok && is_period && in_eff == ppw_pkg::PPW_IN1 &&
     i_cfg.exp_given && i_cfg.exp_ps < ppw_pkg::PS_10NS) |=> setup_r.prescale_on)
    else $error("prescaler off for short input 1 period");
  a_width_avg_fine: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_cfg_valid && state_r == PPW_IDLE && cfg_ok && !is_period &&
     i_cfg.res_given && i_cfg.res_ps < ppw_pkg::PS_1NS) |=> setup_r.avg_on)
    else $error("averaging off for fine width resolution");
  a_trig_units_auto: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_cfg_valid && state_r == PPW_IDLE && cfg_ok && !is_period && i_cfg.ref_given) |=>
    setup_r.auto_trig == $past(i_cfg.ref_percent_units))
    else $error("auto trigger does not follow reference units");
  a_default_input: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_cfg_valid && state_r == PPW_IDLE && cfg_ok && !i_cfg.input_given) |=>
    setup_r.input_sel == ppw_pkg::PPW_IN1)
    else $error("missing input index did not select input 1");
endmodule : ppw_setup

// >>> tb/ppw_sig_src.sv
// Signal source model that drives the measured input lines.
`timescale 1ns/10ps
module ppw_sig_src (
  input  wire logic       i_clk_sys,
  input  wire logic       i_en,
  input  wire logic [1:0] i_sel,
  input  wire logic [7:0] i_hi,
  input  wire logic [7:0] i_lo,
  output logic [2:0]      o_sig
);
  logic [8:0] cnt_r;

  // Steps through one period of the wave, restarting whenever the source is off.
  always_ff @(posedge i_clk_sys) begin
    if (!i_en) begin
      cnt_r <= 9'h000;
    end else if (cnt_r == ({1'b0, i_hi} + {1'b0, i_lo} - 9'h001)) begin
      cnt_r <= 9'h000;
    end else begin
      cnt_r <= cnt_r + 9'h001;
    end
  end

  // one input driven
  // Only the selected line toggles; every line idles low while the source is off.
  assign o_sig = (i_en && (cnt_r < {1'b0, i_hi})) ? (3'h1 << i_sel) : 3'h0;
endmodule : ppw_sig_src

// >>> tb/testbench.sv
// Self-checking testbench for the period and pulse width setup block.
`timescale 1ns/10ps
`define PPW_CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                cfg_valid = 1'b0;
  ppw_pkg::ppw_cfg_t   cfg = '0;
  logic                initiate = 1'b0;
  logic                src_en = 1'b0;
  logic [1:0]          src_sel = 2'h0;
  logic [7:0]          src_hi = 8'h05;
  logic [7:0]          src_lo = 8'h05;
  logic [2:0]          sig;
  logic                cfg_error;
  ppw_pkg::ppw_setup_t setup;
  logic                busy;
  logic                done;
  logic [63:0]         time_count;
  logic [63:0]         cycle_count;
  logic [63:0]         period_ps;
  int                  error_cnt = 0;
  int                  tests_run = 0;
  int                  cyc = 0;
  int                  n;

  // Clock at 100 MHz.
  always #5 clk = ~clk;

  ppw_setup ppw_setup_inst (.i_clk_sys(clk), .i_reset(rst), .i_cfg_valid(cfg_valid), .i_cfg(cfg),
    .i_initiate(initiate), .i_sig_in(sig), .o_cfg_error(cfg_error), .o_setup(setup), .o_busy(busy),
    .o_done(done), .o_time_count(time_count), .o_cycle_count(cycle_count), .o_period_ps(period_ps));
  ppw_sig_src ppw_sig_src_inst (.i_clk_sys(clk), .i_en(src_en), .i_sel(src_sel), .i_hi(src_hi),
    .i_lo(src_lo), .o_sig(sig));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // Cuts a hang short after far more cycles than the scenarios need.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  function automatic ppw_pkg::ppw_cfg_t mk(ppw_pkg::ppw_func_t f, ppw_pkg::ppw_input_t s, logic eg,
      logic [63:0] e, logic rg, logic [63:0] r, logic fg, logic pc, logic [6:0] p);
    return '{f, s != ppw_pkg::PPW_IN_NONE, s, eg, e, rg, r, fg, pc, p};
  endfunction : mk

  // Hands one command over and lets its answer settle.
  task automatic send(input ppw_pkg::ppw_cfg_t c);
    @(posedge clk); cfg <= c; cfg_valid <= 1'b1;
    @(posedge clk); cfg_valid <= 1'b0;
    @(posedge clk); #1;
  endtask : send

  // Restarts the source from the top of its wave and requests a measurement in the same cycle.
  task automatic start(input logic [1:0] s, input logic [7:0] hi, input logic [7:0] lo);
    @(posedge clk); src_en <= 1'b0;
    @(posedge clk); src_en <= 1'b1; src_sel <= s; src_hi <= hi; src_lo <= lo; initiate <= 1'b1;
    @(posedge clk); initiate <= 1'b0;
    #1;
  endtask : start

  // Waits a bounded time for the completion pulse, counting cycles taken.
  task automatic wait_done();
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clk); #1; n++;
    end
    `PPW_CHK(done, 1'b1)
    // The result register takes the final counts one cycle after the pulse.
    @(posedge clk); #1;
  endtask : wait_done

  task automatic t_period_default();
    send(mk(ppw_pkg::PPW_FN_PERIOD, ppw_pkg::PPW_IN_NONE, 0, '0, 0, '0, 0, 0, 7'h00));
    `PPW_CHK(setup.input_sel, ppw_pkg::PPW_IN1)
    `PPW_CHK(setup.digits, 4'h9)
    `PPW_CHK({setup.gate_cyc, setup.prescale_on}, {64'h0000_0000_0262_5A00, 1'b1})
    repeat (10) @(posedge clk);
    `PPW_CHK(busy, 1'b0)
  endtask : t_period_default

  task automatic t_period_measure();
    send(mk(ppw_pkg::PPW_FN_PERIOD, ppw_pkg::PPW_IN1, 1, 64'h186A0, 1, 64'h3E8, 0, 0, 7'h00));
    `PPW_CHK({setup.gate_cyc, setup.prescale_on}, {64'h28, 1'b0})
    start(2'h0, 8'h05, 8'h05);
    `PPW_CHK(busy, 1'b1)
    send(mk(ppw_pkg::PPW_FN_PERIOD, ppw_pkg::PPW_IN2, 0, '0, 0, '0, 0, 0, 7'h00));
    wait_done();
    `PPW_CHK(period_ps, 64'h186A0)
    `PPW_CHK(cycle_count, 64'h5)
    `PPW_CHK(setup.input_sel, ppw_pkg::PPW_IN1)
  endtask : t_period_measure

  task automatic t_prescale();
    send(mk(ppw_pkg::PPW_FN_PERIOD, ppw_pkg::PPW_IN1, 1, 64'h1388, 1, 64'h3E8, 0, 0, 7'h00));
    `PPW_CHK({cfg_error, setup.prescale_on}, 2'h1)
    start(2'h0, 8'h05, 8'h05);
    wait_done();
    `PPW_CHK(period_ps, 64'h186A0)
    `PPW_CHK(cycle_count, 64'h1)
  endtask : t_prescale

  task automatic t_refusals();
    send(mk(ppw_pkg::PPW_FN_PERIOD, ppw_pkg::PPW_IN2, 1, 64'h1388, 0, '0, 0, 0, 7'h00));
    `PPW_CHK({cfg_error, setup.prescale_on}, 2'h3)
    send(mk(ppw_pkg::PPW_FN_POS_WIDTH, ppw_pkg::PPW_IN3, 0, '0, 0, '0, 0, 0, 7'h00));
    `PPW_CHK({cfg_error, setup.func}, 2'h2)
    send(mk(ppw_pkg::PPW_FN_POS_WIDTH, ppw_pkg::PPW_IN1, 0, '0, 0, '0, 1, 1, 7'h5F));
    `PPW_CHK(cfg_error, 1'b1)
    send(mk(ppw_pkg::PPW_FN_PERIOD, ppw_pkg::PPW_IN1, 1, 64'h0035_4A6B_A7A1_8001, 0, '0, 0, 0, 7'h00));
    `PPW_CHK({cfg_error, setup.func}, 2'h2)
    send(mk(ppw_pkg::PPW_FN_PERIOD, ppw_pkg::PPW_IN1, 0, '0, 1, 64'h3E8, 0, 0, 7'h00));
    `PPW_CHK({cfg_error, setup.func}, 2'h2)
    send(mk(ppw_pkg::PPW_FN_POS_WIDTH, ppw_pkg::PPW_IN1, 1, 64'h186A0, 1, 64'h3E8, 0, 0, 7'h00));
    `PPW_CHK({cfg_error, setup.func}, 2'h2)
    send(mk(ppw_pkg::PPW_FN_PERIOD, ppw_pkg::PPW_IN1, 1, 64'h0035_4A6B_A7A1_8000, 0, '0, 0, 0, 7'h00));
    `PPW_CHK({cfg_error, setup.prescale_on}, 2'h0)
  endtask : t_refusals

  task automatic t_width_setup();
    send(mk(ppw_pkg::PPW_FN_POS_WIDTH, ppw_pkg::PPW_IN1, 1, 64'h16E360, 1, 64'h1F4, 1, 1, 7'h4B));
    `PPW_CHK({cfg_error, setup.avg_on, setup.auto_trig, setup.trig_pct}, {3'h3, 7'h4B})
    send(mk(ppw_pkg::PPW_FN_POS_WIDTH, ppw_pkg::PPW_IN2, 0, '0, 0, '0, 1, 0, 7'h00));
    `PPW_CHK({cfg_error, setup.auto_trig}, 2'h0)
  endtask : t_width_setup

  task automatic t_width_measure();
    send(mk(ppw_pkg::PPW_FN_POS_WIDTH, ppw_pkg::PPW_IN2, 1, 64'h186A0, 1, 64'h3E8, 1, 1, 7'h32));
    `PPW_CHK(setup.avg_on, 1'b0)
    start(2'h1, 8'h28, 8'h0A);
    wait_done();
    `PPW_CHK(time_count, 64'h28)
    `PPW_CHK(n >= 40, 1'b1)
  endtask : t_width_measure

  task automatic t_prelim();
    send(mk(ppw_pkg::PPW_FN_POS_WIDTH, ppw_pkg::PPW_IN1, 0, '0, 0, '0, 0, 0, 7'h00));
    `PPW_CHK({setup.auto_trig, setup.trig_pct}, {1'b1, 7'h32})
    start(2'h0, 8'h07, 8'h0D);
    wait_done();
    `PPW_CHK(n > 900, 1'b1)
    `PPW_CHK(time_count, 64'h7)
  endtask : t_prelim

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk); #1;
    `PPW_CHK({setup, busy, done, cfg_error}, '0)
    t_period_default();
    t_period_measure();
    t_prescale();
    t_refusals();
    t_width_setup();
    t_width_measure();
    t_prelim();
    stop_test();
  end
endmodule : testbench
